// ### include/etp_defines.vh
// Constants for the 256-bit transmit stream port: widths, lane layout, codes.
// Assumes inclusion by bare name from the design files.
`ifndef ETP_DEFINES_VH
`define ETP_DEFINES_VH
`define ETP_DATA_W      256
`define ETP_KEEP_W      32
`define ETP_LANE_W      8
`define ETP_CNT_W       6
`define ETP_KEEP_ALL    32'hFFFFFFFF
`define ETP_ERR_BYTE    8'hFE
`define ETP_SYNC_STAGES 2
`define ETP_ST_IDLE     2'h0
`define ETP_ST_FRAME    2'h1
`define ETP_ST_DRAIN    2'h2
`define ETP_THROTTLE_W  4
`endif

// ### logic/etp_reset_sync.v
// Reset resynchroniser: turns an outside reset level into a reset local to clock.
// Assumes resetIn may arrive from any source; output follows it two edges later.
`timescale 1ns/100ps
module etp_reset_sync (
  input  wire clock,
  input  wire resetIn,
  output wire resetOut
);
  reg stage1_q;
  reg stage2_q;

  // Plain two-flop resynchroniser: the reset pins are synchronous levels, so
  // both assertion and release reach the logic two clock edges late
  always @(posedge clock) begin
    stage1_q <= resetIn;
    stage2_q <= stage1_q;
  end

  assign resetOut = stage2_q;
endmodule

// ### logic/etp_tx_stream_port.v
// Transmit stream port: accepts 256-bit frames from the client, one register stage.
// Assumes the client keeps the stream handshake; the downstream MAC takes every word.
//
// Behaviour
// - All port signals timed by clock rising edge; here rst acts asynchronously and throttle is resynchronised
// - Receive reset active high, resynchronised internally
// - Transmit reset active high, resynchronised internally
// - Keep bit n qualifies data bits 8n+7:8n
// - Ready high means presented word is accepted
// - User bit one means bad packet
// - After last, ignore stream until valid again
// - Back-to-back packets delimited only by last
// - Device may drop ready any cycle
// - Bad packet: error code last word, no FCS
// - Valid drop before last aborts frame
`timescale 1ns/100ps
`include "etp_defines.vh"
module etp_tx_stream_port (
  input  wire                      clock,
  input  wire                      rst,
  input  wire                      auxClock,
  input  wire                      txReset,
  input  wire                      rxReset,
  input  wire                      throttle,
  input  wire                      txValid,
  input  wire [`ETP_DATA_W-1:0]    txData,
  input  wire [`ETP_KEEP_W-1:0]    txKeep,
  input  wire                      txLast,
  input  wire                      txUser,
  output reg                       txReady,
  output reg                       macValid,
  output reg  [`ETP_DATA_W-1:0]    macData,
  output reg  [`ETP_KEEP_W-1:0]    macKeep,
  output reg                       macLast,
  output reg                       macBad,
  output reg                       macSkipFcs,
  output reg                       macAbort,
  output reg  [`ETP_CNT_W-1:0]     macByteCount,
  output reg                       rxResetLocal,
  output reg                       frameActive
);
  // Frame states: IDLE between packets, FRAME after a non-last word,
  // DRAIN for the one cycle after an underrun cut the frame short
  localparam ST_IDLE  = `ETP_ST_IDLE;
  localparam ST_FRAME = `ETP_ST_FRAME;
  localparam ST_DRAIN = `ETP_ST_DRAIN;

  wire txRstSync;
  wire rxRstSync;
  wire anyReset;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        throttleMeta_q;
  reg        throttleSync_q;
  reg  [`ETP_DATA_W-1:0] errWord;
  wire       accept;
  integer    i;
  // auxClock is taken in but unused: every register here runs on clock

  // Count set keep bits; used for the byte count only
  function [`ETP_CNT_W-1:0] keepCount;
    input [`ETP_KEEP_W-1:0] keep;
    integer k;
    begin
      keepCount = {`ETP_CNT_W{1'b0}};
      for (k = 0; k < `ETP_KEEP_W; k = k + 1) begin
        keepCount = keepCount + {{(`ETP_CNT_W-1){1'b0}}, keep[k]};
      end
    end
  endfunction

  // Closing word of a bad packet; shared by the flags and the data mux
  function badClose;
    input acc;
    input last;
    input user;
    begin
      badClose = acc & last & user;
    end
  endfunction

  // Resets resynchronised into the one clock domain
  etp_reset_sync uTxRst (
    .clock    (clock),
    .resetIn  (txReset),
    .resetOut (txRstSync)
  );
  etp_reset_sync uRxRst (
    .clock    (clock),
    .resetIn  (rxReset),
    .resetOut (rxRstSync)
  );
  assign anyReset = rst | txRstSync;

  // Receive-side reset is only handed on, registered
  // Registered so the receive side sees a clean level straight from a flop
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rxResetLocal <= 1'b1;
    end else begin
      rxResetLocal <= rxRstSync;
    end
  end

  // Throttle comes from outside the domain: two flops before use
  // A pulse shorter than a clock may be lost, harmless for flow control
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      throttleMeta_q <= 1'b0;
      throttleSync_q <= 1'b0;
    end else begin
      throttleMeta_q <= throttle;
      throttleSync_q <= throttleMeta_q;
    end
  end

  // A word moves only when both sides agree in the same cycle
  assign accept = txValid & txReady;

  // Frame tracking: idle, inside a frame, or draining after an abort
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && !txLast) begin
          state_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (accept && txLast) begin
          state_d = ST_IDLE;
        end else if (!txValid) begin
          state_d = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // A fresh word may open the next frame at once
        if (accept && !txLast) begin
          state_d = ST_FRAME;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Error code bytes in the valid lanes of a bad packet's last word
  // Empty lanes keep their bytes; the MAC ignores them by keep anyway
  always @* begin
    errWord = txData;
    for (i = 0; i < `ETP_KEEP_W; i = i + 1) begin
      if (txKeep[i]) begin
        errWord[i*`ETP_LANE_W +: `ETP_LANE_W] = `ETP_ERR_BYTE;
      end
    end
  end

  // Ready is registered so the client never sees a combinational path back;
  // the cost is one cycle of lag on throttle response
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
    end else if (txRstSync) begin
      txReady <= 1'b0;
    end else begin
      txReady <= ~throttleSync_q;
    end
  end

  // Word capture; held between accepts, so only macValid says a word is new
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      macData      <= {`ETP_DATA_W{1'b0}};
      macKeep      <= {`ETP_KEEP_W{1'b0}};
      macByteCount <= {`ETP_CNT_W{1'b0}};
    end else if (accept && !txRstSync) begin
      macData      <= badClose(1'b1, txLast, txUser) ? errWord : txData;
      macKeep      <= txKeep;
      macByteCount <= keepCount(txKeep);
    end
  end

  // Flags to the MAC pulse for one cycle only, since the MAC never stalls
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      macValid     <= 1'b0;
      macLast      <= 1'b0;
      macBad       <= 1'b0;
      macSkipFcs   <= 1'b0;
      macAbort     <= 1'b0;
      frameActive  <= 1'b0;
    end else if (anyReset) begin
      state_q      <= ST_IDLE;
      macValid     <= 1'b0;
      macLast      <= 1'b0;
      macBad       <= 1'b0;
      macSkipFcs   <= 1'b0;
      macAbort     <= 1'b0;
      frameActive  <= 1'b0;
    end else begin
      state_q      <= state_d;
      frameActive  <= (state_d == ST_FRAME);
      macValid     <= accept;
      macLast      <= accept & txLast;
      macBad       <= badClose(accept, txLast, txUser);
      macSkipFcs   <= badClose(accept, txLast, txUser);
      macAbort     <= (state_q == ST_FRAME) & ~txValid;
    end
  end
endmodule

// ### tb/etp_client_model.sv
// Client frame source on the transmit stream.
// Assumes the bench calls send and idle just after a rising edge.
`timescale 1ns/100ps
module etp_client_model (
  input  wire         clock,
  input  wire         txReady,
  output reg          txValid,
  output reg  [255:0] txData,
  output reg  [31:0]  txKeep,
  output reg          txLast,
  output reg          txUser
);
  integer n;
  initial {txValid, txData, txKeep, txLast, txUser} = {291{1'b0}};
  // Word and sideband stand until the edge that samples ready high
  task send(input [255:0] d, input [31:0] k, input l, input u);
    begin
      {txValid, txData, txKeep, txLast, txUser} <= {1'b1, d, k, l, u};
      n = 0;
      @(posedge clock);
      while (txReady !== 1'b1 && n < 200) begin
        n = n + 1;
        @(posedge clock);
      end
      // Timed out: counted here, and the bench runs on to its closing report
      if (txReady !== 1'b1) begin
        etp_tx_stream_port_tb.mismatches++;
        $display("ERROR txReady expected 1 seen %b", txReady);
      end
    end
  endtask
  // Released lines show inverted data, so stale words never look valid
  task idle;
    begin
      txValid <= 1'b0;
      txLast  <= 1'b0;
      txData  <= ~txData;
    end
  endtask
endmodule

// ### tb/etp_tx_monitor.sv
// Checker on the transmit stream port pins.
// Assumes one clock domain with rst as its reset.
`timescale 1ns/100ps
module etp_tx_monitor (
  input wire         clock,
  input wire         rst,
  input wire         throttle,
  input wire         txValid,
  input wire [255:0] txData,
  input wire [31:0]  txKeep,
  input wire         txLast,
  input wire         txUser,
  input wire         txReady,
  input wire         macValid,
  input wire [255:0] macData,
  input wire [31:0]  macKeep,
  input wire         macLast,
  input wire         macBad,
  input wire         macAbort,
  input wire [5:0]   macByteCount,
  input wire         frameActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A taken word, and a taken closing word
  sequence s_acc; txValid && txReady; endsequence
  sequence s_end; s_acc ##0 txLast; endsequence
  property p_take; s_acc |=> macValid && macKeep == $past(txKeep); endproperty
  a_take: assert property (p_take) else $error("word not passed on");
  property p_idle; !(txValid && txReady) |=> !macValid; endproperty
  a_idle: assert property (p_idle) else $error("word without handshake");
  property p_lane; s_acc ##0 !(txLast && txUser) |=> macData == $past(txData); endproperty
  a_lane: assert property (p_lane) else $error("data lanes moved");
  property p_cnt; macValid |-> macByteCount == $countones(macKeep); endproperty
  a_cnt: assert property (p_cnt) else $error("byte count wrong");
  property p_bad; s_end |=> macLast && macBad == $past(txUser); endproperty
  a_bad: assert property (p_bad) else $error("end or bad flag wrong");
  property p_err; s_end ##0 txUser && txKeep[0] |=> macData[7:0] == 8'hFE; endproperty
  a_err: assert property (p_err) else $error("error code missing");
  property p_abort; frameActive && !txValid |=> macAbort; endproperty
  a_abort: assert property (p_abort) else $error("underrun not flagged");
  property p_thr; throttle [*3] |=> !txReady; endproperty
  a_thr: assert property (p_thr) else $error("ready while throttled");
endmodule
bind etp_tx_stream_port etp_tx_monitor u_mon (.clock, .rst, .throttle, .txValid, .txData,
  .txKeep, .txLast, .txUser, .txReady, .macValid, .macData, .macKeep, .macLast, .macBad,
  .macAbort, .macByteCount, .frameActive);

// ### tb/etp_tx_stream_port_tb.sv
// Bench for the transmit stream port: a table of words, then corner cases.
// Assumes the client model drives the stream and the checker is bound.
`timescale 1ns/100ps
module etp_tx_stream_port_tb;
  typedef struct {logic [255:0] d; logic [31:0] k; logic l, u; logic [255:0] e;
    logic [5:0] c;} etp_row_t;
  etp_row_t rows [5];
  reg clock = 1'b0, rst = 1'b1, auxClock = 1'b0, txReset = 1'b1, rxReset = 1'b1;
  reg throttle = 1'b0;
  wire txValid, txLast, txUser, txReady, macValid, macLast, macBad, macSkipFcs, macAbort;
  wire rxResetLocal, frameActive;
  wire [255:0] txData, macData;
  wire [31:0] txKeep, macKeep;
  wire [5:0] macByteCount;
  integer mismatches = 0, total_checks = 0, i, j;
  int q[$];
  etp_tx_stream_port dut (.clock, .rst, .auxClock, .txReset, .rxReset, .throttle, .txValid,
    .txData, .txKeep, .txLast, .txUser, .txReady, .macValid, .macData, .macKeep, .macLast,
    .macBad, .macSkipFcs, .macAbort, .macByteCount, .rxResetLocal, .frameActive);
  etp_client_model cl (.clock, .txReady, .txValid, .txData, .txKeep, .txLast, .txUser);
  always #5 clock = ~clock;
  always #6.5 auxClock = ~auxClock;
  task chk(input string n, input [255:0] e, input [255:0] g);
    begin
      total_checks++;
      if (e !== g) begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Each word passed on is matched with the oldest outstanding row
  always @(posedge clock) begin
    #1;
    if (macValid === 1'b1) begin
      chk("queued", 1, q.size() > 0);
      j = q.pop_front();
      chk("macData", rows[j].e, macData);
      chk("macKeep", rows[j].k, macKeep);
      chk("macByteCount", rows[j].c, macByteCount);
      chk("macLast", rows[j].l, macLast);
      chk("macBad", rows[j].l & rows[j].u, macBad);
      chk("macSkipFcs", rows[j].l & rows[j].u, macSkipFcs);
      chk("frameActive", !rows[j].l, frameActive);
    end
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    results;
  end
  initial begin
    rows[0] = '{{32{8'h11}}, 32'hFFFFFFFF, 1'b0, 1'b0, {32{8'h11}}, 6'h20};
    rows[1] = '{{32{8'h22}}, 32'h0000000F, 1'b1, 1'b0, {32{8'h22}}, 6'h04};
    rows[2] = '{{32{8'h33}}, 32'h00000001, 1'b1, 1'b0, {32{8'h33}}, 6'h01};
    rows[3] = '{{32{8'h44}}, 32'hFFFFFFFF, 1'b0, 1'b0, {32{8'h44}}, 6'h20};
    rows[4] = '{{32{8'h55}}, 32'h00000003, 1'b1, 1'b1, {{30{8'h55}}, 16'hFEFE}, 6'h02};
    @(posedge clock);
    #1 chk("rxResetLocal", 1, rxResetLocal);
    chk("txReady", 0, txReady);
    @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    {txReset, rxReset} <= 2'h0;
    repeat (6) @(posedge clock);
    #1 chk("rxResetLocal", 0, rxResetLocal);
    $display("test reset done");
    @(posedge clock);
    for (i = 0; i < 5; i++) begin
      q.push_back(i);
      cl.send(rows[i].d, rows[i].k, rows[i].l, rows[i].u);
    end
    cl.idle;
    $display("test rows done");
    throttle <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("txReady", 0, txReady);
    @(posedge clock);
    q.push_back(0);
    fork
      cl.send(rows[0].d, rows[0].k, rows[0].l, rows[0].u);
      begin
        repeat (5) @(posedge clock);
        throttle <= 1'b0;
      end
    join
    cl.idle;
    @(posedge clock);
    #1 chk("macAbort", 1, macAbort);
    $display("test throttle and underrun done");
    @(posedge clock);
    {txReset, rxReset} <= 2'h3;
    repeat (4) @(posedge clock);
    #1 chk("txReady", 0, txReady);
    chk("rxResetLocal", 1, rxResetLocal);
    chk("drained", 0, q.size());
    $display("test stream resets done");
    results;
  end
endmodule
